// File: src/hmc_pkg.sv
// Constants for the host miscellaneous control register bank.
package hmc_pkg;

   // ===========================================================
   // Host register offsets
   localparam logic [7:0] OFS_SCRATCH_TEST  = 8'h00;
   localparam logic [7:0] OFS_PIN_EXTENSION = 8'h05;
   localparam logic [7:0] OFS_SELFTEST_CTRL = 8'h0A;
   localparam logic [7:0] OFS_TSMON_CTRL    = 8'h2F;

   // ===========================================================
   // Reset values
   localparam logic [7:0] RST_SCRATCH_TEST  = 8'h00;
   localparam logic [3:0] RST_PIN_VALUE     = 4'h0;
   localparam logic [3:0] RST_PIN_DIRECTION = 4'hF;
   localparam logic [7:0] RST_SELFTEST_CTRL = 8'h00;
   localparam logic [7:0] RST_TSMON_CTRL    = 8'h00;

   // Value returned for write-only and unmapped offsets
   localparam logic [7:0] RD_NONE           = 8'h00;

   // ===========================================================
   // Pin extension field layout
   localparam int PIN_COUNT   = 4;
   localparam int PIN_DIR_LSB = 0;
   localparam int PIN_VAL_LSB = 4;

   // Self-test field layout
   localparam int ST_AFU_LSB  = 0;
   localparam int AFU_COUNT   = 4;
   localparam int ST_CU_FAIL  = 4;
   localparam int ST_RUN      = 5;

   // Timeslot monitor control field layout
   localparam int MON_CH_LSB  = 0;
   localparam int MON_CH_W    = 5;
   localparam int MON_VALID   = 5;
   localparam int MON_SNAP    = 6;

   // ===========================================================
   // Monitor request states
   typedef enum logic [1:0] {
      HMC_MON_IDLE,
      HMC_MON_WAIT,
      HMC_MON_RUN,
      HMC_MON_HELD
   } hmc_mon_state_t;

endpackage : hmc_pkg

// File: src/hmc_regs.sv
// Host miscellaneous control registers: scratch, pin extension, self-test, monitor select.
//
// Operation
// - Eight-bit scratch at 00H, host read/write, resets to zero, no side effect.
// - Scratch writes are accepted only while write protection is released.
// - Protected writes are gated by the unlock level from the protection register.
// - Pin with direction bit one reads back its sampled pin level.
// - Pin register resets to 0FH; directions low nibble, values high nibble.
// - Host writing run one starts self-test; run bit stays one while running.
// - Hardware clears the run bit when the self-test completes.
// - Fail bits mean something only after a started self-test has finished.
// - Central-unit fail bit is one on RAM error, zero otherwise.
// - One fail bit per filter unit 0 to 3 in bits 0 to 3.
// - Fail bits read-only; self-test register write protected, resets to zero.
// - Write-only monitor control at 2FH reads back as zero.
// - Five-bit channel field selects which timeslot 0 to 31 is captured.
// - Writing monitor-valid one starts a monitor request for the channel.
// - Writing monitor-valid zero clears poll flag and stops continuous updates.
// - Snapshot mode captures once after a valid write, then holds.
// - Snapshot raises interrupt on capture; poll clears on the next monitor control write.
// - Continuous mode with valid set captures every matching timeslot outside a monitor control write cycle.
// - Continuous mode interrupts once per request, on first available data.
// - Availability sets monitor bit in interrupt request and status registers.
`timescale 1ns/1ps
`default_nettype none

module hmc_regs
   import hmc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Host parallel register port
   input  wire logic [7:0] host_addr,
   input  wire logic [7:0] host_wdata,
   input  wire logic       host_wr,
   input  wire logic       host_rd,
   output logic      [7:0] host_rdata,
   // Unlock level from the protection register
   input  wire logic       write_unlocked,
   // General-purpose pins, split into input, output and enable
   input  wire logic [3:0] pin_extension_in,
   output logic      [3:0] pin_extension_out,
   output logic      [3:0] pin_extension_oe,
   // RAM self-test engines
   output logic            selftest_start,
   input  wire logic       selftest_done,
   input  wire logic       central_unit_fail_in,
   input  wire logic [3:0] filter_unit_fail_in,
   // Timeslot processing and monitor capture
   input  wire logic       timeslot_strobe,
   input  wire logic [4:0] timeslot_number,
   output logic      [4:0] monitor_channel_select,
   output logic            monitor_capture,
   output logic            monitor_irq_set,
   output logic            monitor_available_flag,
   output logic            monitor_poll_flag
);

   // ==========================================================
   // Address decoding
   // Shared by the write and read paths so both see one map
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
      addr_hit = (addr == ofs);
   endfunction : addr_hit

   // One write strobe per register
   logic wr_scratch;
   logic wr_pins;
   logic wr_selftest;
   logic wr_monitor;

   // Write strobes per register
   assign wr_scratch  = host_wr && addr_hit(host_addr, OFS_SCRATCH_TEST);
   assign wr_pins     = host_wr && addr_hit(host_addr, OFS_PIN_EXTENSION);
   assign wr_selftest = host_wr && addr_hit(host_addr, OFS_SELFTEST_CTRL);
   assign wr_monitor  = host_wr && addr_hit(host_addr, OFS_TSMON_CTRL);

   // ==========================================================
   // Scratch register
   // Protection lives outside; only its unlock level arrives here
   logic [7:0] scratch_test_ff;

   // Plain storage; only the read path looks at it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         scratch_test_ff <= RST_SCRATCH_TEST;
      end else if (wr_scratch && write_unlocked) begin
         scratch_test_ff <= host_wdata;
      end
   end

   // ==========================================================
   // Pin extension
   // Pin levels taken as synchronous; no extra flops on the way in
   logic [3:0] pin_direction_control_ff;
   logic [3:0] pin_extension_value_ff;
   logic [3:0] pin_read_value;

   // Not protected, so the host can toggle pins at any time
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_direction_control_ff <= RST_PIN_DIRECTION;
         pin_extension_value_ff   <= RST_PIN_VALUE;
      end else if (wr_pins) begin
         pin_direction_control_ff <= host_wdata[PIN_DIR_LSB +: PIN_COUNT];
         pin_extension_value_ff   <= host_wdata[PIN_VAL_LSB +: PIN_COUNT];
      end
   end

   // Per-pin drive and readback mux
   genvar gp;
   generate
      for (gp = 0; gp < PIN_COUNT; gp = gp + 1) begin : g_pin
         // Direction one means input: enable off, read the pin
         assign pin_extension_oe[gp]  = ~pin_direction_control_ff[gp];
         assign pin_extension_out[gp] = pin_extension_value_ff[gp];
         assign pin_read_value[gp]    = pin_direction_control_ff[gp]
                                      ? pin_extension_in[gp]
                                      : pin_extension_value_ff[gp];
      end
   endgenerate

   // ==========================================================
   // RAM self-test control
   // Fail bits are only meaningful once a started run has ended
   logic       selftest_run_ff;
   logic       central_unit_fail_ff;
   logic [3:0] filter_unit_fail_ff;
   logic       selftest_start_ff;
   logic       selftest_go;

   // A second start while running is ignored; the engine has no restart
   assign selftest_go = wr_selftest && write_unlocked && host_wdata[ST_RUN]
                        && !selftest_run_ff;

   // Run bit: host sets, hardware clears on completion
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         selftest_run_ff <= RST_SELFTEST_CTRL[ST_RUN];
      end else if (selftest_go) begin
         selftest_run_ff <= 1'b1;
      end else if (selftest_done && selftest_run_ff) begin
         selftest_run_ff <= 1'b0;
      end
   end

   // Results taken at completion only; host writes never reach them
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         central_unit_fail_ff <= RST_SELFTEST_CTRL[ST_CU_FAIL];
         filter_unit_fail_ff  <= RST_SELFTEST_CTRL[ST_AFU_LSB +: AFU_COUNT];
      end else if (selftest_done && selftest_run_ff) begin
         central_unit_fail_ff <= central_unit_fail_in;
         filter_unit_fail_ff  <= filter_unit_fail_in;
      end
   end

   // One-cycle launch pulse to the test engines
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         selftest_start_ff <= 1'b0;
      end else begin
         selftest_start_ff <= selftest_go;
      end
   end

   // Launch pulse straight from its flop
   assign selftest_start = selftest_start_ff;

   // ==========================================================
   // Timeslot monitor control
   // IDLE off, WAIT armed, RUN continuous after first data, HELD snapshot taken
   logic [4:0]     mon_channel_ff;
   logic           mon_snapshot_ff;
   hmc_mon_state_t mon_state_ff;
   hmc_mon_state_t nxt_mon_state;
   logic           mon_hit;
   logic           mon_first;
   logic           capture_ff;
   logic           irq_set_ff;
   logic           poll_ff;

   // Control fields; nothing of this register is readable
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mon_channel_ff  <= RST_TSMON_CTRL[MON_CH_LSB +: MON_CH_W];
         mon_snapshot_ff <= RST_TSMON_CTRL[MON_SNAP];
      end else if (wr_monitor) begin
         mon_channel_ff  <= host_wdata[MON_CH_LSB +: MON_CH_W];
         mon_snapshot_ff <= host_wdata[MON_SNAP];
      end
   end

   // Selected timeslot passes while a request is live
   assign mon_hit = timeslot_strobe && (timeslot_number == mon_channel_ff)
                    && ((mon_state_ff == HMC_MON_WAIT) || (mon_state_ff == HMC_MON_RUN));
   assign mon_first = mon_hit && (mon_state_ff == HMC_MON_WAIT);

   // Request sequencing; a write takes precedence over a same-cycle hit
   always_comb begin
      nxt_mon_state = mon_state_ff;
      if (wr_monitor) begin
         if (host_wdata[MON_VALID]) begin
            nxt_mon_state = HMC_MON_WAIT;
         end else begin
            nxt_mon_state = HMC_MON_IDLE;
         end
      end else begin
         case (mon_state_ff)
            HMC_MON_WAIT: begin
               if (mon_hit) begin
                  nxt_mon_state = mon_snapshot_ff ? HMC_MON_HELD : HMC_MON_RUN;
               end
            end
            default: begin
               nxt_mon_state = mon_state_ff;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mon_state_ff <= HMC_MON_IDLE;
      end else begin
         mon_state_ff <= nxt_mon_state;
      end
   end

   // Capture on every hit outside a control write; snapshot leaves WAIT after the first one
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         capture_ff <= 1'b0;
      end else begin
         capture_ff <= mon_hit && !wr_monitor;
      end
   end

   // Interrupt on first data only; later hits in RUN stay quiet
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_set_ff <= 1'b0;
      end else begin
         irq_set_ff <= mon_first && !wr_monitor;
      end
   end

   // Poll flag: set by first data, cleared by any monitor control write
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         poll_ff <= 1'b0;
      end else if (mon_first && !wr_monitor) begin
         poll_ff <= 1'b1;
      end else if (wr_monitor) begin
         poll_ff <= 1'b0;
      end
   end

   // Outputs; both status flags share one flop so they never disagree
   assign monitor_channel_select = mon_channel_ff;
   assign monitor_capture        = capture_ff;
   assign monitor_irq_set        = irq_set_ff;
   assign monitor_available_flag = poll_ff;
   assign monitor_poll_flag      = poll_ff;

   // ==========================================================
   // Read path
   // Reads have no side effects, so the host may poll freely
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   // Unmapped and write-only offsets answer zero
   always_comb begin
      nxt_rdata = RD_NONE;
      if (addr_hit(host_addr, OFS_SCRATCH_TEST)) begin
         nxt_rdata = scratch_test_ff;
      end else if (addr_hit(host_addr, OFS_PIN_EXTENSION)) begin
         nxt_rdata = {pin_read_value, pin_direction_control_ff};
      end else if (addr_hit(host_addr, OFS_SELFTEST_CTRL)) begin
         nxt_rdata = {2'b00, selftest_run_ff, central_unit_fail_ff, filter_unit_fail_ff};
      end else if (addr_hit(host_addr, OFS_TSMON_CTRL)) begin
         nxt_rdata = RD_NONE;
      end
   end

   // Read data registered; holds until the next read
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_ff <= RD_NONE;
      end else if (host_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Bus data straight from the read flop
   assign host_rdata = rdata_ff;

endmodule : hmc_regs

`default_nettype wire

// File: dv/hmc_chk.sv
// Concurrent checks on the host control register bank ports.
`timescale 1ns/1ps
`default_nettype none

module hmc_chk
   import hmc_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic       host_wr,
   input wire logic       host_rd,
   input wire logic [7:0] host_rdata,
   input wire logic       write_unlocked,
   input wire logic [3:0] pin_extension_oe,
   input wire logic       selftest_start,
   input wire logic       timeslot_strobe,
   input wire logic [4:0] timeslot_number,
   input wire logic [4:0] monitor_channel_select,
   input wire logic       monitor_capture,
   input wire logic       monitor_irq_set,
   input wire logic       monitor_available_flag,
   input wire logic       monitor_poll_flag
);
   // ==========================================================
   // Assertions, all on the one system clock
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic mon_wr;
   assign mon_wr = host_wr && host_addr == OFS_TSMON_CTRL;
   a_start_cause: assert property (selftest_start |-> $past(host_wr && write_unlocked
      && host_addr == OFS_SELFTEST_CTRL && host_wdata[ST_RUN])) else $error("bad start");
   a_start_pulse: assert property (selftest_start |=> !selftest_start)
      else $error("start too long");
   a_wo_read: assert property (host_rd && host_addr == OFS_TSMON_CTRL |=>
      host_rdata == RD_NONE) else $error("monitor control readable");
   a_chan_load: assert property (mon_wr |=>
      monitor_channel_select == $past(host_wdata[4:0])) else $error("channel not loaded");
   a_poll_clear: assert property (mon_wr |=> !monitor_poll_flag)
      else $error("poll not cleared");
   a_cap_hit: assert property (monitor_capture |->
      $past(timeslot_strobe && timeslot_number == monitor_channel_select))
      else $error("capture without hit");
   a_irq_flags: assert property (monitor_irq_set |->
      monitor_capture && monitor_available_flag) else $error("irq without data");
   a_irq_once: assert property (monitor_irq_set |-> !$past(monitor_available_flag))
      else $error("second irq");
   a_poll_same: assert property (monitor_poll_flag == monitor_available_flag)
      else $error("flags differ");
   a_oe_cause: assert property ($changed(pin_extension_oe) |->
      $past(host_wr && host_addr == OFS_PIN_EXTENSION)) else $error("oe moved alone");
   // Main scenarios reached
   c_start: cover property (selftest_start);
   c_irq: cover property (monitor_irq_set);
   c_recap: cover property (monitor_capture ##[1:20] monitor_capture);
endmodule : hmc_chk

bind hmc_regs hmc_chk hmc_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
   .host_rdata(host_rdata), .write_unlocked(write_unlocked),
   .pin_extension_oe(pin_extension_oe), .selftest_start(selftest_start),
   .timeslot_strobe(timeslot_strobe), .timeslot_number(timeslot_number),
   .monitor_channel_select(monitor_channel_select), .monitor_capture(monitor_capture),
   .monitor_irq_set(monitor_irq_set), .monitor_available_flag(monitor_available_flag),
   .monitor_poll_flag(monitor_poll_flag));
`default_nettype wire

// File: dv/hmc_engine_model.sv
// Behavioural model of the RAM self-test engines.
`timescale 1ns/1ps
`default_nettype none

module hmc_engine_model (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic [4:0] fail_pat,
   output logic            done,
   output logic            cu_fail,
   output logic      [3:0] afu_fail
);
   // ==========================================================
   // Run counter: eight cycles per test
   logic [3:0] cnt_ff;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_ff <= 4'h0;
      end else if (start) begin
         cnt_ff <= 4'h8;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
   // Results are only true with done; garbage otherwise, to catch early sampling
   assign done = cnt_ff == 4'h1;
   assign {cu_fail, afu_fail} = done ? fail_pat : ~fail_pat;
endmodule : hmc_engine_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench for the host control register bank.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import hmc_pkg::*;
   logic       clk_sys = 0, sys_rst = 1, host_wr = 0, host_rd = 0, unl = 0, ts_stb = 0;
   logic [7:0] host_addr = 0, host_wdata = 0, host_rdata;
   logic [3:0] pin_ext = 0, pin_in, pin_out, pin_oe, afu;
   logic [4:0] ts_num = 0, pat = 0, prev = 0, chan;
   logic       start, done, cu, cap, irq, avail, poll;
   int         n_fail = 0, num_checks = 0, n_cap = 0, n_irq = 0;

   // ==========================================================
   // Clock, pin wire and pulse counters
   always #5 clk_sys = ~clk_sys;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
   always @(posedge clk_sys) begin
      n_cap += (cap === 1'b1);
      n_irq += (irq === 1'b1);
   end

   hmc_regs hmc_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
      .host_rdata(host_rdata), .write_unlocked(unl), .pin_extension_in(pin_in),
      .pin_extension_out(pin_out), .pin_extension_oe(pin_oe), .selftest_start(start),
      .selftest_done(done), .central_unit_fail_in(cu), .filter_unit_fail_in(afu),
      .timeslot_strobe(ts_stb), .timeslot_number(ts_num), .monitor_channel_select(chan),
      .monitor_capture(cap), .monitor_irq_set(irq), .monitor_available_flag(avail),
      .monitor_poll_flag(poll));
   hmc_engine_model hmc_engine_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .start(start), .fail_pat(pat), .done(done), .cu_fail(cu), .afu_fail(afu));

   // ==========================================================
   // Host access tasks; strobes are one-cycle pulses
   // The wr, rd and ts tasks return 1 ns after their last edge, so outputs have settled
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      {host_wr, host_addr, host_wdata} <= {1'b1, a, d};
      @(posedge clk_sys);
      host_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      {host_rd, host_addr} <= {1'b1, a};
      @(posedge clk_sys);
      host_rd <= 1'b0;
      #1;
      chk(host_rdata, e);
   endtask : rd
   task automatic ts(input logic [4:0] n);
      @(posedge clk_sys);
      {ts_stb, ts_num} <= {1'b1, n};
      @(posedge clk_sys);
      ts_stb <= 1'b0;
      #1;
   endtask : ts
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   // Watchdog, far beyond the expected hundred or so cycles
   initial begin
      #100000;
      n_fail++;
      close_out();
   end

   // ==========================================================
   // Test sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(OFS_SCRATCH_TEST, 8'h00);
      rd(OFS_PIN_EXTENSION, 8'h0F);
      rd(OFS_SELFTEST_CTRL, 8'h00);
      @(posedge clk_sys) pin_ext <= 4'h5;
      wr(OFS_SCRATCH_TEST, 8'h5A);
      wr(OFS_SELFTEST_CTRL, 8'h20);
      rd(OFS_SCRATCH_TEST, 8'h00);
      rd(OFS_SELFTEST_CTRL, 8'h00);
      @(posedge clk_sys) unl <= 1'b1;
      wr(OFS_SCRATCH_TEST, 8'hAA);
      rd(OFS_SCRATCH_TEST, 8'hAA);
      $display("test scratch done");
      // Pins 1:0 inputs, 3:2 outputs driving 1 and 0
      wr(OFS_PIN_EXTENSION, 8'hA3);
      rd(OFS_PIN_EXTENSION, 8'h93);
      chk({pin_oe, pin_out}, 8'hCA);
      $display("test pins done");
      // Two runs; fail bits written as ones must be ignored
      for (int i = 0; i < 2; i++) begin
         pat <= i ? 5'h0A : 5'h15;
         wr(OFS_SELFTEST_CTRL, 8'h3F);
         rd(OFS_SELFTEST_CTRL, {3'b001, prev});
         for (int k = 0; k < 20 && done !== 1'b1; k++) @(posedge clk_sys);
         @(posedge clk_sys);
         prev = pat;
         rd(OFS_SELFTEST_CTRL, {3'b000, prev});
      end
      $display("test selftest done");
      rd(8'h01, RD_NONE);
      // Snapshot request on channel 5: one capture only
      wr(OFS_TSMON_CTRL, 8'h65);
      chk({3'h0, chan}, 8'h05);
      rd(OFS_TSMON_CTRL, RD_NONE);
      ts(5'd5);
      ts(5'd9);
      ts(5'd5);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(8'(n_cap), 8'h01);
      chk(8'(n_irq), 8'h01);
      chk({6'h0, avail, poll}, 8'h03);
      // Continuous request on channel 3: every hit, one irq
      wr(OFS_TSMON_CTRL, 8'h23);
      chk({6'h0, avail, poll}, 8'h00);
      repeat (3) ts(5'd3);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(8'(n_cap), 8'h04);
      chk(8'(n_irq), 8'h02);
      // Valid cleared: poll drops and updates stop
      wr(OFS_TSMON_CTRL, 8'h03);
      ts(5'd3);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({poll, avail, 6'(n_cap)}, 8'h04);
      $display("test monitor done");
      // Protection back on: scratch keeps its old value
      @(posedge clk_sys) unl <= 1'b0;
      wr(OFS_SCRATCH_TEST, 8'h55);
      rd(OFS_SCRATCH_TEST, 8'hAA);
      $display("test relock done");
      close_out();
   end
endmodule : tb
`default_nettype wire
